/* File: core/watchdog_timeout_irq_reset.sv */
// Watchdog timer with an AHB-Lite register slave, interrupt and system reset.
`timescale 1ns/1ps
// Behaviour
// - Counter counts down from the selected timeout; reaching zero is a timeout.
// - At zero the counter reloads the selected timeout and keeps counting.
// - Only a write of 0x76 to the restart register restarts the counter.
// - Response mode 1: timeout raises the interrupt, a later timeout may reset.
// - Response mode 0: timeout asserts the system reset directly.
// - Option 0: second timeout resets only if the interrupt is still pending.
// - Option 1: second timeout resets even if the interrupt was cleared.
// - Without separate clock, interrupt appears only after bus-side edge detection.
// - With separate clock, interrupt asserts one bus cycle after the timer-side interrupt.
// - Separate clock: timer-side interrupt self-clears after bus-side edge detection.
// - Separate clock: interrupt output is the OR of timer-side and bus-side interrupts.
// - Interrupt holds until interrupt-clear read or restart-magic write.
// - Separate clock: interrupt sets on timer edge, clears on bus clock.
// - Block reset deasserts the system reset output at the next bus clock rise.
// - Counter width is a parameter from 16 to 32 bits.
// - Register data width is configurable as 8, 16 or 32 bits.
// - Optional second timeout period used after the first restart.
// - Count reads are coherent across the low and the high access.
// - External clock enable gates the counter decrement rate.
// - A restart coinciding with zero count produces no system reset.
module watchdog_timeout_irq_reset
    import wdog_pkg::*;
#(
    parameter int CNT_WIDTH = 32,
    parameter int DATA_WIDTH = 32,
    parameter bit DUAL_PERIOD = 1'b1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic timer_clk,
    input wire logic wdt_clk_en,
    output logic wdt_irq,
    output logic wdt_sys_rst
);
    // =========================================================================
    // Elaboration checks.
    initial begin
        if (CNT_WIDTH < 16 || CNT_WIDTH > 32) begin
            $error("Counter width must lie between 16 and 32.");
        end
        if (DATA_WIDTH != 8 && DATA_WIDTH != 16 && DATA_WIDTH != 32) begin
            $error("Data width must be 8, 16 or 32.");
        end
    end

    // =========================================================================
    // Pin synchronisers for the timer clock and the clock enable.
    logic tclk_s1_reg, tclk_s2_reg, tclk_s3_reg;
    logic cen_s1_reg, cen_s2_reg;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tclk_s1_reg <= 1'b0;
            tclk_s2_reg <= 1'b0;
            tclk_s3_reg <= 1'b0;
            cen_s1_reg <= 1'b0;
            cen_s2_reg <= 1'b0;
        end else begin
            tclk_s1_reg <= timer_clk;
            tclk_s2_reg <= tclk_s1_reg;
            tclk_s3_reg <= tclk_s2_reg;
            cen_s1_reg <= wdt_clk_en;
            cen_s2_reg <= cen_s1_reg;
        end
    end
    logic tick;
    // One-cycle counting enable on each timer clock rise while the enable is high.
    assign tick = tclk_s2_reg & ~tclk_s3_reg & cen_s2_reg;

    // =========================================================================
    // AHB-Lite address phase capture.
    logic ap_valid_reg, ap_write_reg;
    logic [ADDR_BITS-1:0] ap_addr_reg;
    logic take;
    assign take = hsel & htrans[1] & hready;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= '0;
        end else begin
            ap_valid_reg <= take;
            ap_write_reg <= hwrite;
            ap_addr_reg <= haddr[ADDR_BITS-1:0];
        end
    end
    logic wr_en, rd_take;
    assign wr_en = ap_valid_reg & ap_write_reg;
    assign rd_take = take & ~hwrite;
    logic [DATA_WIDTH-1:0] wdata;
    assign wdata = hwdata[DATA_WIDTH-1:0];

    // =========================================================================
    // Control and period registers.
    logic [CTRL_WIDTH-1:0] ctrl_reg;
    logic [CNT_WIDTH-1:0] period_first_reg, period_next_reg;
    logic enable, response_mode_field, every2, sepclk;
    assign enable = ctrl_reg[CTRL_EN_BIT];
    assign response_mode_field = ctrl_reg[CTRL_RESP_MODE_BIT];
    assign every2 = ctrl_reg[CTRL_EVERY2_BIT];
    assign sepclk = ctrl_reg[CTRL_SEPCLK_BIT];
    // Control writes; the enable bit may be set but never cleared by software.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_en && ap_addr_reg == CTRL_OFS) begin
            ctrl_reg <= hwdata[CTRL_WIDTH-1:0];
            ctrl_reg[CTRL_EN_BIT] <= hwdata[CTRL_EN_BIT] | enable;
        end
    end
    // Bus bits that land in a period register; a narrow counter ignores the rest.
    localparam int PER_BITS = (DATA_WIDTH < CNT_WIDTH) ? DATA_WIDTH : CNT_WIDTH;
    // Period writes; bits above the bus width keep their value.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            period_first_reg <= PERIOD_RESET[CNT_WIDTH-1:0];
            period_next_reg <= PERIOD_RESET[CNT_WIDTH-1:0];
        end else if (wr_en) begin
            if (ap_addr_reg == PERIOD_FIRST_OFS) begin
                period_first_reg[PER_BITS-1:0] <= wdata[PER_BITS-1:0];
            end
            if (ap_addr_reg == PERIOD_NEXT_OFS) begin
                period_next_reg[PER_BITS-1:0] <= wdata[PER_BITS-1:0];
            end
        end
    end

    // =========================================================================
    // Restart request, held until the next counting tick.
    logic restart_pending_reg, first_kick_done_reg;
    logic magic_wr;
    assign magic_wr = wr_en && ap_addr_reg == RESTART_OFS && hwdata[7:0] == RESTART_MAGIC;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            restart_pending_reg <= 1'b0;
        end else if (magic_wr) begin
            restart_pending_reg <= 1'b1;
        end else if (tick) begin
            restart_pending_reg <= 1'b0;
        end
    end
    // Records that the first restart has happened, selecting the second period.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            first_kick_done_reg <= 1'b0;
        end else if (tick && restart_pending_reg && enable) begin
            first_kick_done_reg <= 1'b1;
        end
    end
    logic [CNT_WIDTH-1:0] reload_val;
    // A pending restart already selects the second period for the reload it causes.
    assign reload_val = (DUAL_PERIOD && (first_kick_done_reg || (restart_pending_reg && enable)))
                        ? period_next_reg : period_first_reg;

    // =========================================================================
    // Down counter with reload of the selected period at zero.
    logic [CNT_WIDTH-1:0] count_reg;
    logic timeout_evt;
    assign timeout_evt = enable & tick & ~restart_pending_reg & (count_reg == '0);
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count_reg <= PERIOD_RESET[CNT_WIDTH-1:0];
        end else if (!enable) begin
            count_reg <= reload_val;
        end else if (tick) begin
            if (restart_pending_reg || count_reg == '0) begin
                count_reg <= reload_val;
            end else begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // =========================================================================
    // Interrupt: timer-side flag, bus-side edge flag and the combined output.
    logic timer_domain_irq_reg, timer_irq_prev_reg, bus_domain_irq_edge_reg;
    logic eoi_rd, irq_clear, irq_rise, irq_set;
    assign eoi_rd = rd_take && haddr[ADDR_BITS-1:0] == IRQ_CLEAR_OFS;
    assign irq_clear = eoi_rd | magic_wr;
    assign irq_set = timeout_evt & response_mode_field;
    assign irq_rise = timer_domain_irq_reg & ~timer_irq_prev_reg;
    // The timer-side flag clears once the bus side has seen its edge.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            timer_domain_irq_reg <= 1'b0;
            timer_irq_prev_reg <= 1'b0;
        end else begin
            timer_irq_prev_reg <= timer_domain_irq_reg;
            if (irq_set) begin
                timer_domain_irq_reg <= 1'b1;
            end else if (bus_domain_irq_edge_reg) begin
                timer_domain_irq_reg <= 1'b0;
            end
        end
    end
    // Bus-side flag: a new edge wins over a clear in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_domain_irq_edge_reg <= 1'b0;
        end else if (irq_rise) begin
            bus_domain_irq_edge_reg <= 1'b1;
        end else if (irq_clear) begin
            bus_domain_irq_edge_reg <= 1'b0;
        end
    end
    logic irq_next;
    assign irq_next = sepclk ? (timer_domain_irq_reg | bus_domain_irq_edge_reg)
                             : bus_domain_irq_edge_reg;
    // Registered interrupt output; sets on a timer tick, clears on a bus access.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wdt_irq <= 1'b0;
        end else begin
            wdt_irq <= irq_next;
        end
    end

    // =========================================================================
    // System reset decision.
    logic second_pending_reg, irq_still;
    assign irq_still = timer_domain_irq_reg | bus_domain_irq_edge_reg;
    // Remembers a timeout since the last restart for the every-second option.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            second_pending_reg <= 1'b0;
        end else if (irq_set) begin
            second_pending_reg <= 1'b1;
        end else if (magic_wr) begin
            second_pending_reg <= 1'b0;
        end
    end
    // Reset asserts on timeout per mode and stays until the block reset.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wdt_sys_rst <= 1'b0;
        end else if (timeout_evt) begin
            if (!response_mode_field) begin
                wdt_sys_rst <= 1'b1;
            end else if (every2 && second_pending_reg) begin
                wdt_sys_rst <= 1'b1;
            end else if (!every2 && irq_still) begin
                wdt_sys_rst <= 1'b1;
            end
        end
    end

    // =========================================================================
    // Read data, coherent count snapshot and bus answer.
    logic [CNT_WIDTH-1:0] snap_reg;
    logic [31:0] rd_value;
    logic [31:0] count_ext, snap_ext, first_ext, next_ext;
    assign count_ext = 32'(count_reg);
    assign snap_ext = 32'(snap_reg);
    assign first_ext = 32'(period_first_reg);
    assign next_ext = 32'(period_next_reg);
    always_comb begin
        rd_value = 32'h0000_0000;
        case (haddr[ADDR_BITS-1:0])
            CTRL_OFS: rd_value = 32'(ctrl_reg);
            PERIOD_FIRST_OFS: rd_value = first_ext;
            PERIOD_NEXT_OFS: rd_value = next_ext;
            COUNT_OFS: rd_value = count_ext;
            COUNT_HI_OFS: rd_value = snap_ext >> DATA_WIDTH;
            STATUS_OFS: begin
                rd_value[STAT_IRQ_BIT] = wdt_irq;
                rd_value[STAT_RST_BIT] = wdt_sys_rst;
                rd_value[STAT_PEND_BIT] = restart_pending_reg;
                rd_value[STAT_FIRST_BIT] = first_kick_done_reg;
            end
            default: rd_value = 32'h0000_0000;
        endcase
    end
    // Reading the low count part freezes the whole value for the high part.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            snap_reg <= '0;
        end else if (rd_take && haddr[ADDR_BITS-1:0] == COUNT_OFS) begin
            snap_reg <= count_reg;
        end
    end
    // Read data is loaded at the address phase and stands in the data phase.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
            if (rd_take) begin
                hrdata <= rd_value & ((DATA_WIDTH == 32) ? 32'hFFFF_FFFF
                                      : ((32'h1 << DATA_WIDTH) - 32'h1));
            end
        end
    end

    // =========================================================================
    // Assertions.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_restart_only_magic: assert property (
        !$past(restart_pending_reg) && restart_pending_reg |-> $past(magic_wr))
        else $error("Restart armed without the magic write.");
    a_count_reload_zero: assert property (
        enable && tick && count_reg == '0 |=> count_reg == $past(reload_val))
        else $error("Counter did not reload at zero.");
    a_count_decrement: assert property (
        enable && tick && !restart_pending_reg && count_reg != '0
        |=> count_reg == $past(count_reg) - 1'b1)
        else $error("Counter did not decrement.");
    a_mode0_direct_reset: assert property (
        timeout_evt && !response_mode_field |=> wdt_sys_rst)
        else $error("Mode 0 timeout gave no system reset.");
    a_restart_no_reset: assert property (
        tick && restart_pending_reg && !wdt_sys_rst |=> !wdt_sys_rst)
        else $error("Restart at zero count produced a reset.");
    a_enable_sticky: assert property (
        enable |=> enable)
        else $error("Enable bit was cleared by software.");
    a_irq_clear_read: assert property (
        eoi_rd && !irq_rise |=> !bus_domain_irq_edge_reg ##1 !wdt_irq || irq_set)
        else $error("Interrupt not cleared by the clear read.");
    a_sep_irq_fast: assert property (
        irq_set && sepclk |=> ##1 wdt_irq)
        else $error("Separate-clock interrupt was late.");
    a_second_uncleared: assert property (
        timeout_evt && response_mode_field && !every2 && !irq_still && !wdt_sys_rst
        |=> !wdt_sys_rst)
        else $error("Reset fired though the interrupt was cleared.");
    a_every2_reset: assert property (
        timeout_evt && response_mode_field && every2 && second_pending_reg |=> wdt_sys_rst)
        else $error("Second timeout gave no reset with option 1.");
    // Reset hold, interrupt routing, second period, counter hold and read snapshot checks.
    a_sysrst_sticky: assert property (
        wdt_sys_rst |=> wdt_sys_rst)
        else $error("System reset dropped without a block reset.");
    a_nonsep_irq_late: assert property (
        irq_set && !sepclk && !bus_domain_irq_edge_reg |=> !wdt_irq ##1 !wdt_irq)
        else $error("Interrupt appeared before bus-side edge detection.");
    a_timer_irq_selfclear: assert property (
        bus_domain_irq_edge_reg && !irq_set |=> !timer_domain_irq_reg)
        else $error("Timer-side interrupt did not clear after edge detection.");
    a_sep_irq_or: assert property (
        sepclk |=> wdt_irq == $past(timer_domain_irq_reg | bus_domain_irq_edge_reg))
        else $error("Interrupt output is not the OR of both flags.");
    a_restart_second_period: assert property (
        enable && tick && restart_pending_reg
        |=> count_reg == (DUAL_PERIOD ? $past(period_next_reg) : $past(period_first_reg)))
        else $error("Restart did not reload the second period.");
    a_mode0_no_irq: assert property (
        timeout_evt && !response_mode_field && !timer_domain_irq_reg |=> !timer_domain_irq_reg)
        else $error("Mode 0 timeout raised the interrupt.");
    a_gated_count_hold: assert property (
        enable && !tick |=> count_reg == $past(count_reg))
        else $error("Counter moved without a counting tick.");
    a_count_snapshot: assert property (
        rd_take && haddr[ADDR_BITS-1:0] == COUNT_OFS |=> snap_reg == $past(count_reg))
        else $error("Count snapshot is not the value read.");
endmodule : watchdog_timeout_irq_reset

/* File: core/wdog_pkg.sv */
// Package with register map, field positions and constants of the watchdog.
package wdog_pkg;
    // =========================================================================
    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PERIOD_FIRST_OFS = 8'h04;
    localparam logic [7:0] COUNT_OFS = 8'h08;
    localparam logic [7:0] RESTART_OFS = 8'h0C;
    localparam logic [7:0] IRQ_CLEAR_OFS = 8'h10;
    localparam logic [7:0] PERIOD_NEXT_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    localparam logic [7:0] COUNT_HI_OFS = 8'h1C;
    localparam int ADDR_BITS = 8;
    // =========================================================================
    // Control register fields.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RESP_MODE_BIT = 1;
    localparam int CTRL_EVERY2_BIT = 2;
    localparam int CTRL_SEPCLK_BIT = 3;
    localparam int CTRL_WIDTH = 4;
    // Status register fields.
    localparam int STAT_IRQ_BIT = 0;
    localparam int STAT_RST_BIT = 1;
    localparam int STAT_PEND_BIT = 2;
    localparam int STAT_FIRST_BIT = 3;
    // =========================================================================
    // Magic restart value, reset values and bus codes.
    localparam logic [7:0] RESTART_MAGIC = 8'h76;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 4'h0;
    localparam logic [31:0] PERIOD_RESET = 32'h0000_FFFF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : wdog_pkg

/* File: verification/timer_source.sv */
// Model of the external timer clock source and counter enable.
`timescale 1ns/1ps
module timer_source (
    input wire logic run,
    input wire logic gate,
    output logic timer_clk,
    output logic wdt_clk_en
);
    // =========================================================================
    // Clock generation.
    // The clock starts off phase with the bus clock and stands low while stopped.
    initial begin
        timer_clk = 1'b0;
        #3;
        forever begin
            #62.5;
            timer_clk = run ? ~timer_clk : 1'b0;
        end
    end
    // The enable follows the gate request and sets the decrement rate.
    assign wdt_clk_en = gate;
endmodule : timer_source

/* File: verification/tb.sv */
// Self-checking testbench of the watchdog over its AHB-Lite registers.
`timescale 1ns/1ps
module tb
    import wdog_pkg::*;
;
    logic ref_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
    logic timer_clk, wdt_clk_en, wdt_irq, wdt_sys_rst, run, gate;
    logic [31:0] haddr, hwdata, hrdata, x;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int failures, checked;
    // The only slave drives the bus ready.
    assign hready = hreadyout;
    watchdog_timeout_irq_reset watchdog_timeout_irq_reset_i (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .timer_clk(timer_clk), .wdt_clk_en(wdt_clk_en),
        .wdt_irq(wdt_irq), .wdt_sys_rst(wdt_sys_rst));
    timer_source timer_source_i (.run(run), .gate(gate), .timer_clk(timer_clk),
        .wdt_clk_en(wdt_clk_en));
    // The bus clock toggles every half period.
    always #5 ref_clk = ~ref_clk;
    // =========================================================================
    // Tasks.
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task final_report;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    // Waits for the slave to be ready at a rising edge, with a bound.
    task edge_ready;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            check("hready", 32'h0, 32'h1);
            final_report();
        end
    endtask : edge_ready
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
              output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        edge_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        edge_ready();
        rd = hrdata;
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] y;
        xfer(1'b1, a, d, y);
    endtask : wr
    task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] y;
        xfer(1'b0, a, 32'h0, y);
        check(name, y, exp);
    endtask : rd_chk
    // Waits a bounded time for the interrupt or the system reset to rise.
    task wait_out(input bit irq, input int lim);
        int n;
        n = 0;
        while (((irq ? wdt_irq : wdt_sys_rst) !== 1'b1) && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= lim) begin
            check(irq ? "irq_wait" : "rst_wait", 32'h0, 32'h1);
            final_report();
        end
    endtask : wait_out
    task do_reset;
        // The reset request is sticky, so the bench resets the block once at start and after each time it sees it.
        sys_rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check("sys_rst_out", {31'h0, wdt_sys_rst}, 32'h0);
    endtask : do_reset
    // =========================================================================
    // Main sequence.
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        run = 1'b0;
        gate = 1'b1;
        failures = 0;
        checked = 0;
        @(posedge ref_clk);
        do_reset();
        rd_chk("ctrl", CTRL_OFS, {28'h0, CTRL_RESET});
        rd_chk("period", PERIOD_FIRST_OFS, PERIOD_RESET);
        rd_chk("next", PERIOD_NEXT_OFS, PERIOD_RESET);
        rd_chk("status", STATUS_OFS, 32'h0);
        wr(8'h20, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h20, 32'h0);
        check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
        $display("test reset_values done");
        wr(PERIOD_FIRST_OFS, 32'h3);
        wr(PERIOD_NEXT_OFS, 32'h5);
        wr(CTRL_OFS, 32'h1);
        rd_chk("count", COUNT_OFS, 32'h3);
        wr(RESTART_OFS, 32'h75);
        rd_chk("pending", STATUS_OFS, 32'h0);
        wr(CTRL_OFS, 32'h0);
        rd_chk("ctrl_en", CTRL_OFS, 32'h1);
        wr(RESTART_OFS, {24'h0, RESTART_MAGIC});
        rd_chk("pending", STATUS_OFS, 32'h4);
        run <= 1'b1;
        repeat (20) @(posedge ref_clk);
        run <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rd_chk("first_done", STATUS_OFS, 32'h8);
        xfer(1'b0, COUNT_OFS, 32'h0, x);
        check("count_reload", {31'h0, (x === 32'h5 || x === 32'h4)}, 32'h1);
        rd_chk("count_again", COUNT_OFS, x);
        rd_chk("count_hi", COUNT_HI_OFS, 32'h0);
        $display("test restart done");
        run <= 1'b1;
        wait_out(1'b0, 400);
        check("irq_mode0", {31'h0, wdt_irq}, 32'h0);
        do_reset();
        $display("test reset_mode done");
        gate <= 1'b0;
        wr(PERIOD_FIRST_OFS, 32'h3);
        wr(CTRL_OFS, 32'h3);
        repeat (80) @(posedge ref_clk);
        rd_chk("count_gated", COUNT_OFS, 32'h3);
        gate <= 1'b1;
        wait_out(1'b1, 400);
        check("rst_first", {31'h0, wdt_sys_rst}, 32'h0);
        rd_chk("clear", IRQ_CLEAR_OFS, 32'h0);
        @(posedge ref_clk);
        check("irq_clear", {31'h0, wdt_irq}, 32'h0);
        wait_out(1'b1, 400);
        repeat (3) @(posedge ref_clk);
        check("rst_cleared", {31'h0, wdt_sys_rst}, 32'h0);
        wait_out(1'b0, 400);
        check("irq_held", {31'h0, wdt_irq}, 32'h1);
        do_reset();
        $display("test irq_mode done");
        wr(PERIOD_FIRST_OFS, 32'h3);
        wr(CTRL_OFS, 32'h7);
        wait_out(1'b1, 400);
        rd_chk("clear", IRQ_CLEAR_OFS, 32'h0);
        @(posedge ref_clk);
        check("rst_early", {31'h0, wdt_sys_rst}, 32'h0);
        wait_out(1'b0, 400);
        do_reset();
        $display("test every_second done");
        wr(PERIOD_FIRST_OFS, 32'h3);
        wr(CTRL_OFS, 32'hB);
        wait_out(1'b1, 400);
        check("rst_sep", {31'h0, wdt_sys_rst}, 32'h0);
        wr(RESTART_OFS, {24'h0, RESTART_MAGIC});
        // The write clears at its data-phase edge; the output flop follows one edge later.
        repeat (2) @(posedge ref_clk);
        check("irq_restart", {31'h0, wdt_irq}, 32'h0);
        $display("test separate_clock done");
        final_report();
    end
endmodule : tb
